// ==== hdl/ext_bus_pkg.sv ====
// Constants and types shared by the external bus interface
package ext_bus_pkg;

	// ****************************************
	// Bus geometry
	// ****************************************
	localparam int ADDR_W    = 24;
	localparam int DATA_W    = 16;
	localparam int LANE_W    = 8;
	localparam int SPACES    = 4;
	localparam int WIDE_SPACE_CNT = 3;
	localparam int NARROW_SPACE   = 3;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS  = 8;
	localparam int ADDR_PHASE_NS  = 16;
	localparam int STROBE_MIN_NS  = 24;
	localparam int ADDR_CYC   = (ADDR_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W      = 4;
	localparam logic [CNT_W-1:0] ADDR_LAST   = CNT_W'(ADDR_CYC - 1);
	localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYC - 1);

	// Cycles after reset release before straps are caught
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [SPACES-1:0] CS_IDLE_N = 4'hf;
	localparam logic [DATA_W-1:0] DATA_RST  = 16'h0000;
	localparam logic [ADDR_W-2:0] ADDR_RST  = 23'h000000;

	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_ADDR   = 5'h02,
		ST_STROBE = 5'h04,
		ST_END    = 5'h08,
		ST_HOLD   = 5'h10
	} bus_state_t;

endpackage

// ==== hdl/pin_sync.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_state_t;

	sync_state_t s_q;
	sync_state_t s_d;

	always_comb
	begin
		s_d        = s_q;
		s_d.first  = pin_in;
		s_d.second = s_q.first;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign sync_out = s_q.second;

endmodule
`default_nettype wire

// ==== hdl/strobe_decode.sv ====
// Strobe levels for one access in either strobe style
`timescale 1ns/10ps
`default_nettype none

module strobe_decode (
	input  wire logic single_style,
	input  wire logic write,
	input  wire logic odd,
	input  wire logic word,
	input  wire logic wide,
	output logic      rd_n,
	output logic      lo_n,
	output logic      hi_n
);

	always_comb
	begin
		rd_n = write;                                   // R13
		if (single_style)
		begin
			lo_n = !write;                              // R14
			hi_n = !(odd || word);                      // R15
		end
		else
		begin
			lo_n = !(write && wide && (!odd || word));  // R11
			hi_n = !(write && (odd || word));           // R12
		end
	end

endmodule
`default_nettype wire

// ==== hdl/ext_bus_if.sv ====
// External memory bus sequencer with hold and wait handling
//
// Overview of operation
// R01: Everything stays in reset while reset_n is held low.
// R02: Mode strap low gives single-chip mode, high gives microprocessor mode.
// R03: Space 3 is 16 bits wide with width pin low, 8 bits when high.
// R04: Board holds the width pin fixed, low in single-chip mode.
// R05: Separate bus carries the low byte on lines 0-7; 8-15 only when wide.
// R06: Address bits 0-22 go out true, the top address bit inverted.
// R07: Multiplexed bus sends address 0-7 then data 0-7 on the low lines.
// R08: Wide multiplexed bus sends address 8-15 then data 8-15 on upper lines.
// R09: Four chip selects, each low during an access to its space.
// R10: A setting picks per-byte write strobes or one write strobe plus lane enable.
// R11: Per-byte style on a wide bus: low strobe low writes even addresses.
// R12: Per-byte style: high strobe low writes odd addresses.
// R13: Per-byte style: read strobe low while reading.
// R14: Single style: write strobe low to write, read strobe low to read.
// R15: Single style: upper lane enable low whenever an odd address is accessed.
// R16: Software picks single style whenever the bus is 8 bits wide.
// R17: An address latch strobe marks when the address may be captured.
// R18: Hold request low puts the bus into and keeps it in hold.
// R19: Release grant is low exactly while in hold.
// R20: Wait input low keeps the current access in its strobe phase.
// R21: In hold, address, data, selects and strobes float.
// R22: Wait is sampled each clock of strobe; each low sample adds one clock. The code samples it only once the strobe count has reached zero.
`timescale 1ns/10ps
`default_nettype none

module ext_bus_if #(
	parameter int ADDR_W = ext_bus_pkg::ADDR_W,
	parameter int DATA_W = ext_bus_pkg::DATA_W
) (
	input  wire logic              clk,
	input  wire logic              reset_n,
	// Straps and bus control pins
	input  wire logic              processor_mode_pin,
	input  wire logic              bus_width_pin,
	input  wire logic              hold_request_n,
	input  wire logic              wait_request_n,
	// Configuration
	input  wire logic              single_strobe_style,
	input  wire logic              multiplexed_bus,
	// Request side
	input  wire logic              req,
	input  wire logic              req_write,
	input  wire logic              req_word,
	input  wire logic [1:0]        req_space,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	output logic                   busy,
	output logic                   done,
	output logic                   refused,
	output logic      [DATA_W-1:0] rdata,
	output logic                   microprocessor_mode,
	output logic                   space3_narrow,
	// Address pins
	output logic      [ADDR_W-2:0] address_out,
	output logic                   top_address_bit,
	output logic                   address_oe,
	// Shared address/data lanes
	input  wire logic [7:0]        lane_lo_in,
	output logic      [7:0]        lane_lo_out,
	output logic                   lane_lo_oe,
	input  wire logic [7:0]        lane_hi_in,
	output logic      [7:0]        lane_hi_out,
	output logic                   lane_hi_oe,
	// Control pins
	output logic      [3:0]        chip_select_lines_n,
	output logic                   read_strobe_n,
	output logic                   low_byte_store_strobe_n,
	output logic                   high_byte_store_strobe_n,
	output logic                   address_latch,
	output logic                   control_oe,
	output logic                   bus_release_grant_n
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		ext_bus_pkg::bus_state_t state;
		logic [ext_bus_pkg::CNT_W-1:0] cnt;
		logic [1:0]        strap_cnt;
		logic              strap_done;
		logic              mode;
		logic              narrow3;
		logic              write;
		logic              word;
		logic              odd;
		logic              wide;
		logic [DATA_W-1:0] wdata;
		logic [ADDR_W-2:0] addr;
		logic              top;
		logic              addr_oe;
		logic [7:0]        lo_out;
		logic              lo_oe;
		logic [7:0]        hi_out;
		logic              hi_oe;
		logic [3:0]        cs_n;
		logic              rd_n;
		logic              lo_n;
		logic              hi_n;
		logic              ale;
		logic              ctl_oe;
		logic              grant_n;
		logic              busy;
		logic              done;
		logic              refused;
		logic [DATA_W-1:0] rdata;
	} bus_regs_t;

	bus_regs_t s_q;
	bus_regs_t s_d;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [19:0] pins_sync;
	logic        mode_s;
	logic        width_s;
	logic        hold_s_n;
	logic        wait_s_n;
	logic [7:0]  lo_s;
	logic [7:0]  hi_s;

	pin_sync #(
		.WIDTH (20)
	) u_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.pin_in   ({processor_mode_pin, bus_width_pin, hold_request_n,
		            wait_request_n, lane_hi_in, lane_lo_in}),
		.sync_out (pins_sync)
	);

	assign mode_s   = pins_sync[19];
	assign width_s  = pins_sync[18];
	assign hold_s_n = pins_sync[17];
	assign wait_s_n = pins_sync[16];
	assign hi_s     = pins_sync[15:8];
	assign lo_s     = pins_sync[7:0];

	// ****************************************
	// Strobe levels for the held access
	// ****************************************
	logic dec_rd_n;
	logic dec_lo_n;
	logic dec_hi_n;

	strobe_decode u_decode (
		.single_style (single_strobe_style), // R10
		.write        (s_q.write),
		.odd          (s_q.odd),
		.word         (s_q.word),
		.wide         (s_q.wide),
		.rd_n         (dec_rd_n),
		.lo_n         (dec_lo_n),
		.hi_n         (dec_hi_n)
	);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic space_is_wide(input logic [1:0] space, input logic narrow3);
		space_is_wide = !(space == 2'(ext_bus_pkg::NARROW_SPACE) && narrow3);  // R03
	endfunction

	function automatic logic [3:0] select_for(input logic [1:0] space);
		select_for = ~(4'h1 << space);
	endfunction

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb
	begin
		s_d         = s_q;
		s_d.done    = 1'b0;
		s_d.refused = 1'b0;

		// Straps are caught once the synchronisers have settled
		if (!s_q.strap_done)
		begin
			if (s_q.strap_cnt == ext_bus_pkg::STRAP_SETTLE)
			begin
				s_d.strap_done = 1'b1;
				s_d.mode       = mode_s;                        // R02
				s_d.narrow3    = width_s;                       // R03
				s_d.addr_oe    = mode_s;
				s_d.ctl_oe     = mode_s;
			end
			else
				s_d.strap_cnt = s_q.strap_cnt + 2'h1;
		end

		case (s_q.state)
			ext_bus_pkg::ST_IDLE:
			begin
				if (s_q.strap_done && !hold_s_n)
				begin
					s_d.state   = ext_bus_pkg::ST_HOLD;          // R18
					s_d.grant_n = 1'b0;                          // R19
					s_d.addr_oe = 1'b0;                          // R21
					s_d.ctl_oe  = 1'b0;                          // R21
					s_d.lo_oe   = 1'b0;
					s_d.hi_oe   = 1'b0;
					s_d.busy    = 1'b1;
				end
				else if (req && s_q.strap_done)
				begin
					if (!s_q.mode
					    || (req_word && req_addr[0])
					    || (req_word && !space_is_wide(req_space, s_q.narrow3)))
						s_d.refused = 1'b1;
					else
					begin
						s_d.state = ext_bus_pkg::ST_ADDR;
						s_d.cnt   = ext_bus_pkg::ADDR_LAST;
						s_d.busy  = 1'b1;
						s_d.write = req_write;
						s_d.word  = req_word;
						s_d.odd   = req_addr[0];
						s_d.wide  = space_is_wide(req_space, s_q.narrow3);
						s_d.wdata = req_wdata;
						s_d.addr  = req_addr[ADDR_W-2:0];        // R06
						s_d.top   = !req_addr[ADDR_W-1];         // R06
						s_d.cs_n  = select_for(req_space);       // R09
						s_d.ale   = 1'b1;                        // R17
						if (single_strobe_style)
							s_d.hi_n = !(req_addr[0] || req_word); // R15
						if (multiplexed_bus)
						begin
							s_d.lo_out = req_addr[7:0];          // R07
							s_d.lo_oe  = 1'b1;                   // R07
							s_d.hi_out = req_addr[15:8];         // R08
							s_d.hi_oe  = space_is_wide(req_space, s_q.narrow3); // R08
						end
					end
				end
			end

			ext_bus_pkg::ST_ADDR:
			begin
				if (s_q.cnt == '0)
				begin
					s_d.state = ext_bus_pkg::ST_STROBE;
					s_d.cnt   = ext_bus_pkg::STROBE_LAST;
					s_d.ale   = 1'b0;
					s_d.rd_n  = dec_rd_n;                        // R13
					s_d.lo_n  = dec_lo_n;                        // R11
					s_d.hi_n  = dec_hi_n;                        // R12
					if (s_q.write)
					begin
						// Odd byte rides the upper lane only on a wide bus
						if (s_q.wide && s_q.odd && !s_q.word)
							s_d.hi_out = s_q.wdata[7:0];
						else
							s_d.hi_out = s_q.wdata[15:8];
						s_d.lo_out = s_q.wdata[7:0];             // R05
						s_d.lo_oe  = 1'b1;                       // R05
						s_d.hi_oe  = s_q.wide;                   // R05
					end
					else
					begin
						s_d.lo_oe = 1'b0;
						s_d.hi_oe = 1'b0;
					end
				end
				else
					s_d.cnt = s_q.cnt - 4'h1;
			end

			ext_bus_pkg::ST_STROBE:
			begin
				if (s_q.cnt != '0)
					s_d.cnt = s_q.cnt - 4'h1;
				else if (wait_s_n)                              // R20 R22
				begin
					s_d.state = ext_bus_pkg::ST_END;
					s_d.rd_n  = 1'b1;
					s_d.lo_n  = 1'b1;
					if (!single_strobe_style)
						s_d.hi_n = 1'b1;
					if (!s_q.write)
					begin
						if (s_q.word)
							s_d.rdata = {hi_s, lo_s};
						else if (s_q.wide && s_q.odd)
							s_d.rdata = {8'h00, hi_s};
						else
							s_d.rdata = {8'h00, lo_s};
					end
				end
			end

			ext_bus_pkg::ST_END:
			begin
				s_d.state = ext_bus_pkg::ST_IDLE;
				s_d.cs_n  = ext_bus_pkg::CS_IDLE_N;
				s_d.hi_n  = 1'b1;
				s_d.lo_oe = 1'b0;
				s_d.hi_oe = 1'b0;
				s_d.busy  = 1'b0;
				s_d.done  = 1'b1;
			end

			ext_bus_pkg::ST_HOLD:
			begin
				if (hold_s_n)
				begin
					s_d.state   = ext_bus_pkg::ST_IDLE;
					s_d.grant_n = 1'b1;                          // R19
					s_d.addr_oe = s_q.mode;
					s_d.ctl_oe  = s_q.mode;
					s_d.busy    = 1'b0;
				end
			end

			default:
			begin
				s_d.state = ext_bus_pkg::ST_IDLE;
				s_d.busy  = 1'b0;
			end
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)                                           // R01
		begin
			s_q            <= '0;
			s_q.state      <= ext_bus_pkg::ST_IDLE;
			s_q.addr       <= ext_bus_pkg::ADDR_RST;
			s_q.top        <= 1'b1;
			s_q.wdata      <= ext_bus_pkg::DATA_RST;
			s_q.rdata      <= ext_bus_pkg::DATA_RST;
			s_q.cs_n       <= ext_bus_pkg::CS_IDLE_N;
			s_q.rd_n       <= 1'b1;
			s_q.lo_n       <= 1'b1;
			s_q.hi_n       <= 1'b1;
			s_q.grant_n    <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign busy                     = s_q.busy;
	assign done                     = s_q.done;
	assign refused                  = s_q.refused;
	assign rdata                    = s_q.rdata;
	assign microprocessor_mode      = s_q.mode;
	assign space3_narrow            = s_q.narrow3;
	assign address_out              = s_q.addr;
	assign top_address_bit          = s_q.top;
	assign address_oe               = s_q.addr_oe;
	assign lane_lo_out              = s_q.lo_out;
	assign lane_lo_oe               = s_q.lo_oe;
	assign lane_hi_out              = s_q.hi_out;
	assign lane_hi_oe               = s_q.hi_oe;
	assign chip_select_lines_n      = s_q.cs_n;
	assign read_strobe_n            = s_q.rd_n;
	assign low_byte_store_strobe_n  = s_q.lo_n;
	assign high_byte_store_strobe_n = s_q.hi_n;
	assign address_latch            = s_q.ale;
	assign control_oe               = s_q.ctl_oe;
	assign bus_release_grant_n      = s_q.grant_n;

endmodule
`default_nettype wire

// ==== verif/ext_bus_mem.sv ====
// Behavioural external memory on the far side of the bus
`timescale 1ns/10ps
`default_nettype none

module ext_bus_mem (
	input  wire logic       clk,
	input  wire logic       single,
	input  wire logic       mux,
	input  wire logic [3:0] cs_n,
	input  wire logic       rd_n,
	input  wire logic       lo_n,
	input  wire logic       hi_n,
	input  wire logic       latch,
	input  wire logic [4:0] addr,
	input  wire logic [7:0] lo_out,
	input  wire logic [7:0] hi_out,
	output logic      [7:0] lo_in,
	output logic      [7:0] hi_in
);
	logic [7:0] lo_m [0:15];
	logic [7:0] hi_m [0:15];
	logic [7:0] lo_l = 8'h00;
	logic [7:0] hi_l = 8'h00;
	logic [4:0] a_q  = 5'h00;
	logic       rd;

	assign rd = (cs_n != 4'hf) && !rd_n;
	// Released lanes show the inverse of the last value
	assign lo_in = rd ? lo_m[a_q[4:1]] : ~lo_l;
	assign hi_in = rd ? hi_m[a_q[4:1]] : ~hi_l;

	always @(posedge clk)
	begin
		lo_l <= lo_in;
		hi_l <= hi_in;
		if (latch)
			a_q <= mux ? lo_out[4:0] : addr;
		if (cs_n != 4'hf && !lo_n && (!single || !a_q[0]))
			lo_m[a_q[4:1]] <= lo_out;
		if (cs_n != 4'hf && !hi_n && (!single || !lo_n))
			hi_m[a_q[4:1]] <= hi_out;
	end
endmodule
`default_nettype wire

// ==== verif/ext_bus_if_asserts.sv ====
// Concurrent checks on the external bus sequencer pins
`timescale 1ns/10ps
`default_nettype none

module ext_bus_if_asserts (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       hold_request_n,
	input  wire logic       wait_request_n,
	input  wire logic       busy,
	input  wire logic       done,
	input  wire logic       refused,
	input  wire logic       address_oe,
	input  wire logic       control_oe,
	input  wire logic       lane_lo_oe,
	input  wire logic       lane_hi_oe,
	input  wire logic [3:0] chip_select_lines_n,
	input  wire logic       read_strobe_n,
	input  wire logic       low_byte_store_strobe_n,
	input  wire logic       high_byte_store_strobe_n,
	input  wire logic       address_latch,
	input  wire logic       bus_release_grant_n
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	a_hold_float: assert property (!bus_release_grant_n |-> !(address_oe | control_oe | lane_lo_oe | lane_hi_oe))
		else $error("bus driven during hold");
	a_grant_end: assert property (hold_request_n[*5] ##0 !bus_release_grant_n |-> ##1 bus_release_grant_n)
		else $error("grant kept after hold released");
	a_one_select: assert property (address_latch |-> $countones(chip_select_lines_n) == 3)
		else $error("not exactly one chip select");
	a_read_store: assert property (!read_strobe_n |-> low_byte_store_strobe_n)
		else $error("read and store strobes together");
	a_strobe_min: assert property ($fell(read_strobe_n) |-> !read_strobe_n[*3])
		else $error("strobe phase too short");
	a_latch_len: assert property ($rose(address_latch) |-> address_latch[*2] ##1 !address_latch)
		else $error("address latch width wrong");
	a_latch_next: assert property ($fell(address_latch) |->
		!(read_strobe_n & low_byte_store_strobe_n & high_byte_store_strobe_n))
		else $error("no strobe after address latch");
	a_wait_hold: assert property (!read_strobe_n && !$past(wait_request_n, 1) && !$past(wait_request_n, 2)
		&& !$past(wait_request_n, 3) |=> !read_strobe_n)
		else $error("strobe ended during wait");
	a_done_idle: assert property (done |-> chip_select_lines_n == 4'hf && !lane_lo_oe && !lane_hi_oe && !busy)
		else $error("bus not idle at done");

	c_done: cover property (done);
	c_hold: cover property (!bus_release_grant_n);
	c_refused: cover property (refused);
endmodule

bind ext_bus_if ext_bus_if_asserts i_chk (.*);
`default_nettype wire

// ==== verif/external_memory_bus_interface_tb.sv ====
// Self-checking bench for the external bus sequencer
`timescale 1ns/10ps
`default_nettype none

module external_memory_bus_interface_tb;
	logic        clk = 1'b0;
	logic        reset_n, processor_mode_pin, bus_width_pin, hold_request_n, wait_request_n;
	logic        single_strobe_style, multiplexed_bus, req, req_write, req_word;
	logic [1:0]  req_space, got;
	logic [23:0] req_addr, adr_l;
	logic [15:0] req_wdata, rdata;
	logic        busy, done, refused, microprocessor_mode, space3_narrow, lo_seen, hi_seen, hi_drv;
	logic [22:0] address_out;
	logic        top_address_bit, address_oe, lane_lo_oe, lane_hi_oe, control_oe;
	logic [7:0]  lane_lo_in, lane_lo_out, lane_hi_in, lane_hi_out, lat_lo, lat_hi;
	logic [3:0]  chip_select_lines_n, cs_l;
	logic        read_strobe_n, low_byte_store_strobe_n, high_byte_store_strobe_n;
	logic        address_latch, bus_release_grant_n;
	int          miscompares = 0;
	int          tests_run = 0;
	int          cycles = 0;
	int          rd_cnt;

	always #4 clk = ~clk;

	ext_bus_if i_dut (.*);

	ext_bus_mem i_mem (
		.clk    (clk),
		.single (single_strobe_style),
		.mux    (multiplexed_bus),
		.cs_n   (chip_select_lines_n),
		.rd_n   (read_strobe_n),
		.lo_n   (low_byte_store_strobe_n),
		.hi_n   (high_byte_store_strobe_n),
		.latch  (address_latch),
		.addr   (address_out[4:0]),
		.lo_out (lane_lo_out),
		.hi_out (lane_hi_out),
		.lo_in  (lane_lo_in),
		.hi_in  (lane_hi_in)
	);

	task automatic final_report;
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		tests_run++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic acc(input logic w, input logic wd, input logic [1:0] sp, input logic [23:0] a,
		input logic [15:0] d);
		int n;
		@(negedge clk);
		{req, req_write, req_word, req_space, req_addr, req_wdata} = {1'b1, w, wd, sp, a, d};
		{rd_cnt, lo_seen, hi_seen, hi_drv, got} = '0;
		for (n = 0; n < 60 && got == 2'h0; n++)
		begin
			@(negedge clk);
			if (busy | refused)
				req = 1'b0;
			if (address_latch)
				{cs_l, lat_lo, lat_hi, adr_l} = {chip_select_lines_n, lane_lo_out, lane_hi_out,
					top_address_bit, address_out};
			rd_cnt += !read_strobe_n;
			lo_seen |= !low_byte_store_strobe_n;
			hi_seen |= !high_byte_store_strobe_n;
			hi_drv |= lane_hi_oe;
			got = {done, refused};
		end
	endtask

	task automatic rst(input logic m, input logic w);
		@(negedge clk);
		{reset_n, processor_mode_pin, bus_width_pin} = {1'b0, m, w};
		repeat (5) @(negedge clk);
		chk({bus_release_grant_n, chip_select_lines_n, address_oe, control_oe, top_address_bit, busy}, 9'h1f2);
		reset_n = 1'b1;
		repeat (6) @(negedge clk);
		chk({microprocessor_mode, space3_narrow}, {m, w});
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			miscompares++;
			final_report();
		end
	end

	initial
	begin
		{reset_n, hold_request_n, wait_request_n, processor_mode_pin, bus_width_pin} = 5'h0c;
		{single_strobe_style, multiplexed_bus, req, req_write, req_word, req_space, req_addr, req_wdata} = '0;
		rst(1'b1, 1'b0);
		acc(1'b1, 1'b1, 2'h0, 24'h000010, 16'ha55a);
		chk({got, lo_seen, hi_seen, cs_l}, 8'hbe);
		chk(hi_drv, 1'b1);
		acc(1'b1, 1'b0, 2'h0, 24'h000011, 16'h003c);
		chk({got, lo_seen, hi_seen}, 4'h9);
		acc(1'b1, 1'b0, 2'h0, 24'h000010, 16'h0096);
		chk({got, lo_seen, hi_seen}, 4'ha);
		acc(1'b0, 1'b1, 2'h0, 24'h000010, 16'h0000);
		chk({rdata, lo_seen, hi_seen}, {16'h3c96, 2'h0});
		chk(24'(rd_cnt), 24'(ext_bus_pkg::STROBE_CYC));
		acc(1'b0, 1'b0, 2'h0, 24'h000011, 16'h0000);
		chk(rdata[7:0], 8'h3c);
		acc(1'b0, 1'b1, 2'h0, 24'h000011, 16'h0000);
		chk(got, 2'h1);
		for (int s = 0; s < 4; s++)
		begin
			acc(1'b1, 1'b1, s[1:0], {s[0], 23'h000020}, 16'h1234);
			chk({got, cs_l}, {2'h2, ~(4'h1 << s)});
			chk(adr_l, {~s[0], 23'h000020});
		end
		multiplexed_bus = 1'b1;
		acc(1'b1, 1'b1, 2'h1, 24'h00c3b4, 16'h5aa5);
		chk({lat_hi, lat_lo}, 16'hc3b4);
		acc(1'b0, 1'b1, 2'h1, 24'h00c3b4, 16'h0000);
		chk(rdata, 16'h5aa5);
		multiplexed_bus = 1'b0;
		single_strobe_style = 1'b1;
		acc(1'b1, 1'b1, 2'h2, 24'h000030, 16'h7e81);
		chk({got, lo_seen, hi_seen}, 4'hb);
		acc(1'b1, 1'b0, 2'h2, 24'h000031, 16'h0024);
		chk({got, lo_seen, hi_seen}, 4'hb);
		acc(1'b1, 1'b0, 2'h2, 24'h000030, 16'h00db);
		chk({got, lo_seen, hi_seen}, 4'ha);
		wait_request_n = 1'b0;
		fork
			acc(1'b0, 1'b1, 2'h2, 24'h000030, 16'h0000);
			begin
				repeat (7) @(negedge clk);
				wait_request_n = 1'b1;
			end
		join
		chk({rdata, lo_seen}, {16'h24db, 1'b0});
		chk(24'(rd_cnt), 24'(ext_bus_pkg::STROBE_CYC + 3));
		hold_request_n = 1'b0;
		repeat (5) @(negedge clk);
		chk({bus_release_grant_n, address_oe, control_oe, lane_lo_oe, lane_hi_oe}, 5'h0);
		hold_request_n = 1'b1;
		repeat (5) @(negedge clk);
		chk({bus_release_grant_n, address_oe, control_oe}, 3'h7);
		rst(1'b1, 1'b1);
		acc(1'b0, 1'b1, 2'h3, 24'h000040, 16'h0000);
		chk(got, 2'h1);
		acc(1'b1, 1'b0, 2'h3, 24'h000041, 16'h0077);
		chk({got, lo_seen, hi_seen}, 4'hb);
		chk(hi_drv, 1'b0);
		rst(1'b0, 1'b0);
		acc(1'b0, 1'b1, 2'h0, 24'h000010, 16'h0000);
		chk({got, address_oe, control_oe}, 4'h4);
		final_report();
	end
endmodule
`default_nettype wire
